// ### core/pport_core.sv
/*
 * Host-side parallel port, printer (output only) or scanner (bidirectional).
 * Assumes synchronous inputs from the peripheral; pad logic resolves the
 * three-signal data and fault pins.
 */
// What this block does
// - Data lines output-only printer, bidirectional scanner
// - Low busy means peripheral cannot accept data
// - Paper-out is paper end or fault
// - Selected input: printer selected or scanner ready
// - Fault pin: printer error in, scanner busy out
// - Select output picks peripheral, registered from select request
// - Printer mode drives line feed request
`default_nettype none
module pport_core
	import pport_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              scanner_mode_i,
	input  wire logic              scan_direction_i,
	input  wire logic              line_feed_req_i,
	input  wire logic              select_req_i,
	input  wire logic              peer_reset_req_i,
	input  wire logic              host_busy_i,
	input  wire logic [DATA_W-1:0] tx_data_i,
	input  wire logic              tx_valid_i,
	output logic                   tx_ready_o,
	output logic [DATA_W-1:0]      rx_data_o,
	output logic                   rx_valid_o,
	input  wire logic              rx_ready_i,
	input  wire logic [DATA_W-1:0] port_data_lines_i,
	output logic [DATA_W-1:0]      port_data_lines_o,
	output logic                   port_data_lines_oe_b_o,
	input  wire logic              peer_received_flag_i,
	input  wire logic              busy_b_i,
	input  wire logic              paper_out_fault_b_i,
	input  wire logic              peer_selected_b_i,
	input  wire logic              fault_line_i,
	output logic                   fault_line_o,
	output logic                   fault_line_oe_b_o,
	output logic                   select_peer_out_o,
	output logic                   line_feed_or_direction_o,
	output logic                   byte_valid_pulse_o,
	output logic                   peer_reset_out_o,
	output logic                   paper_end_o,
	output logic                   peer_fault_o,
	output logic                   printer_selected_o,
	output logic                   scanner_ready_o,
	output logic                   printer_error_o
);
	typedef struct packed
	{
		logic [1:0][DATA_W-1:0] buf_data;
		logic [1:0]             buf_full;
		logic                   wr_ptr;
		logic                   rd_ptr;
		xfer_e                  xfer;
		logic [CNT_W-1:0]       cnt;
		logic [DATA_W-1:0]      out_data;
		logic [DATA_W-1:0]      rx_data;
		logic                   rx_valid;
		logic                   strobe;
		logic                   select;
		logic                   lfd;
		logic                   prst;
		logic                   fault_out;
	} state_s;

	state_s st;
	state_s next_st;
	logic   scan_in;
	logic   print_scan_select;
	logic   peer_busy;

	assign print_scan_select = scanner_mode_i ? !scan_direction_i : 1'h1;
	assign scan_in = scanner_mode_i && !print_scan_select;
	// Busy applies in printer mode, and in scanner mode only while printing
	assign peer_busy = !busy_b_i && print_scan_select;
	assign tx_ready_o = !st.buf_full[st.wr_ptr];

	always_comb
	begin
		next_st = st;
		next_st.select = select_req_i;
		next_st.lfd = scanner_mode_i ? print_scan_select : line_feed_req_i;
		next_st.prst = peer_reset_req_i;
		next_st.fault_out = host_busy_i;
		if (tx_valid_i && tx_ready_o)
		begin
			next_st.buf_data[st.wr_ptr] = tx_data_i;
			next_st.buf_full[st.wr_ptr] = 1'h1;
			next_st.wr_ptr = !st.wr_ptr;
		end
		if (rx_valid_o && rx_ready_i)
			next_st.rx_valid = 1'h0;
		unique case (st.xfer)
			ST_IDLE:
			begin
				if (scan_in && !peer_selected_b_i && !st.rx_valid)
				begin
					next_st.rx_data = port_data_lines_i;
					next_st.rx_valid = 1'h1;
				end
				else if (!scan_in && st.buf_full[st.rd_ptr] && !peer_busy)
				begin
					next_st.out_data = st.buf_data[st.rd_ptr];
					next_st.buf_full[st.rd_ptr] = 1'b0;
					next_st.rd_ptr = !st.rd_ptr;
					next_st.strobe = 1'h1;
					next_st.cnt = STROBE_CNT;
					next_st.xfer = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				if (st.cnt == CNT_ONE)
				begin
					next_st.strobe = 1'h0;
					next_st.xfer = ST_WAIT;
				end
				else
					next_st.cnt = st.cnt - CNT_ONE;
			end
			ST_WAIT:
				if (peer_received_flag_i)
					next_st.xfer = ST_IDLE;
			default:
				next_st.xfer = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st <= '0;
			st.xfer <= ST_IDLE;
			st.out_data <= DATA_RST;
		end
		else
			st <= next_st;
	end

	assign rx_data_o = st.rx_data;
	assign rx_valid_o = st.rx_valid;
	assign port_data_lines_o = st.out_data;
	assign port_data_lines_oe_b_o = scan_in;
	assign fault_line_o = st.fault_out;
	assign fault_line_oe_b_o = !scanner_mode_i;
	assign select_peer_out_o = st.select;
	assign line_feed_or_direction_o = st.lfd;
	assign byte_valid_pulse_o = st.strobe;
	assign peer_reset_out_o = st.prst;
	assign paper_end_o = !scanner_mode_i && !paper_out_fault_b_i;
	assign peer_fault_o = scanner_mode_i && !paper_out_fault_b_i;
	assign printer_selected_o = !scanner_mode_i && !peer_selected_b_i;
	assign scanner_ready_o = scanner_mode_i && !peer_selected_b_i;
	assign printer_error_o = !scanner_mode_i && fault_line_i;

	// Strobe pulse: rising step, then held for the full strobe width
	sequence strobe_start;
		$rose(byte_valid_pulse_o);
	endsequence
	sequence strobe_held;
		byte_valid_pulse_o [*5] ##1 !byte_valid_pulse_o;
	endsequence

	AST_STROBE_LEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		strobe_start |-> strobe_held)
		else $error("strobe width wrong");
	AST_NO_DRIVE_SCAN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(scanner_mode_i && scan_direction_i) |-> port_data_lines_oe_b_o)
		else $error("data driven while scanning");
	AST_PRINTER_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!scanner_mode_i |-> !port_data_lines_oe_b_o)
		else $error("printer data not driven");
	AST_BUSY_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st.xfer == ST_IDLE && peer_busy) |=> !$rose(byte_valid_pulse_o))
		else $error("strobe while busy");
	AST_WAIT_ACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st.xfer == ST_WAIT && !peer_received_flag_i) |=> st.xfer == ST_WAIT)
		else $error("left wait without ack");
	AST_FAULT_DIR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		scanner_mode_i |-> !fault_line_oe_b_o)
		else $error("fault line not driven in scanner");
	AST_DIR_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(scanner_mode_i && $stable(scanner_mode_i)) |=>
		line_feed_or_direction_o == !$past(scan_direction_i))
		else $error("direction output wrong");
	AST_SELECT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		select_req_i |=> select_peer_out_o)
		else $error("select not driven");
	AST_RESET_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		peer_reset_req_i |=> peer_reset_out_o)
		else $error("peer reset not driven");
	AST_PAPER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!paper_out_fault_b_i |-> (paper_end_o == !scanner_mode_i) && (peer_fault_o == scanner_mode_i))
		else $error("paper status misrouted");
	AST_PAPER_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		paper_out_fault_b_i |-> !paper_end_o && !peer_fault_o)
		else $error("paper status without report");
	AST_LFD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!scanner_mode_i && line_feed_req_i && $stable(scanner_mode_i)) |=>
		line_feed_or_direction_o)
		else $error("line feed not driven");

	AST_NO_SEND_SCAN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st.xfer == ST_IDLE && scan_in) |=> !$rose(byte_valid_pulse_o))
		else $error("strobe started while scanning");
	AST_STROBE_DATA: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(byte_valid_pulse_o && $past(byte_valid_pulse_o)) |-> $stable(port_data_lines_o))
		else $error("data moved under strobe");
	AST_RX_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rx_valid_o && !rx_ready_i) |=> (rx_valid_o && $stable(rx_data_o)))
		else $error("scanned byte lost in stall");
	AST_FAULT_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(scanner_mode_i && host_busy_i) |=> fault_line_o)
		else $error("host busy not driven");
endmodule : pport_core
`default_nettype wire

// ### core/pport_pkg.sv
/*
 * Constants and types shared by the printer/scanner parallel port.
 * Assumes a single 10 MHz system clock and synchronous active-low reset.
 */
`default_nettype none
package pport_pkg;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned CLK_NS      = 100;
	localparam int unsigned STROBE_NS   = 500;
	localparam int unsigned STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CNT_W       = 4;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic MODE_PRINTER = 1'h0;
	localparam logic MODE_SCANNER = 1'h1;

	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'h0,
		ST_STROBE = 2'h1,
		ST_WAIT   = 2'h3
	} xfer_e;
endpackage : pport_pkg
`default_nettype wire

// ### sim/pport_peer.sv
/*
 * Peripheral model: takes strobed bytes, acks them, drives scan bytes.
 * Assumes the host strobes, then waits for the ack.
 */
`default_nettype none
module pport_peer
(
	input  wire logic       clk_i,
	input  wire logic       strobe_i,
	input  wire logic [7:0] data_i,
	input  wire logic       busy_i,
	input  wire logic       scan_en_i,
	input  wire logic [7:0] scan_data_i,
	output logic [7:0]      data_o,
	output logic            ack_o,
	output logic            busy_b_o,
	output logic            ready_b_o,
	output logic [7:0]      got_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen = 1'b0;
	logic late = 1'b0;
	always @(posedge clk_i)
	begin
		seen <= strobe_i;
		late <= seen & ~strobe_i;
		if (strobe_i & ~seen)
			got_o <= data_i;
	end
	assign ack_o = late;
	assign busy_b_o = ~busy_i;
	assign ready_b_o = ~scan_en_i;
	// Undriven bus shows the inverse rather than a stale byte
	assign data_o = scan_en_i ? scan_data_i : ~scan_data_i;
endmodule : pport_peer
`default_nettype wire

// ### sim/test_pport_core.sv
/*
 * Bench for the parallel port core with a peripheral model.
 * Assumes a 100 ns clock and inputs driven 1 ns after the edge.
 */
`default_nettype none
module test_pport_core;
	import pport_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_b_i = 0, mode = 0, dir = 0, lf = 0, ctl = 0, bsy = 0;
	logic pof_b = 1, err = 0, txv = 0, rxr = 0, scn = 0;
	logic [7:0] txd = 8'h00, scd = 8'h00, dq_host, dq_peer, dq, got, rxd;
	logic stb, ack, bb, rb, txr, rxv, oe_b, foe_b, fo, sel, lfd, rso;
	logic pend, pflt, psel, srdy, perr;
	int fails = 0, checked = 0, cyc = 0;
	assign dq = (oe_b === 1'b0) ? dq_host : dq_peer;
	always #50 clk_i = ~clk_i;
	pport_core pport_core_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .scanner_mode_i(mode),
		.scan_direction_i(dir), .line_feed_req_i(lf), .select_req_i(ctl),
		.peer_reset_req_i(ctl), .host_busy_i(bsy), .tx_data_i(txd), .tx_valid_i(txv),
		.tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr),
		.port_data_lines_i(dq), .port_data_lines_o(dq_host), .port_data_lines_oe_b_o(oe_b),
		.peer_received_flag_i(ack), .busy_b_i(bb), .paper_out_fault_b_i(pof_b),
		.peer_selected_b_i(rb), .fault_line_i(foe_b ? err : fo), .fault_line_o(fo),
		.fault_line_oe_b_o(foe_b), .select_peer_out_o(sel), .line_feed_or_direction_o(lfd),
		.byte_valid_pulse_o(stb), .peer_reset_out_o(rso), .paper_end_o(pend),
		.peer_fault_o(pflt), .printer_selected_o(psel), .scanner_ready_o(srdy),
		.printer_error_o(perr));
	pport_peer pport_peer_inst (.clk_i(clk_i), .strobe_i(stb), .data_i(dq), .busy_i(bsy),
		.scan_en_i(scn), .scan_data_i(scd), .data_o(dq_peer), .ack_o(ack), .busy_b_o(bb),
		.ready_b_o(rb), .got_o(got));
	task give_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails = fails + 1;
			give_verdict;
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task tk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tk
	task send(input logic [7:0] b);
		txd = b;
		txv = 1;
		while (txr !== 1'b1)
			tk(1);
		tk(1);
		txv = 0;
		tk(1);
	endtask : send
	task watch(input logic [7:0] e);
		int n;
		n = 0;
		while (stb !== 1'b1)
			tk(1);
		chk(dq_host, e);
		chk({7'h00, oe_b}, 8'h00);
		while (stb === 1'b1)
		begin
			tk(1);
			n++;
		end
		chk(8'(n), 8'(STROBE_CYC));
		chk(got, e);
	endtask : watch
	task t_print;
		lf = 1;
		ctl = 1;
		send(8'hA5);
		watch(8'hA5);
		chk({lfd, sel, rso}, 3'h7);
		$display("print test done");
	endtask : t_print
	task t_busy;
		bsy = 1;
		send(8'h5A);
		send(8'hC3);
		chk({stb, txr}, 2'h0);
		bsy = 0;
		watch(8'h5A);
		watch(8'hC3);
		$display("busy test done");
	endtask : t_busy
	task t_status;
		{pof_b, err, scn} = 3'h3;
		tk(1);
		chk({pend, psel, perr, foe_b}, 4'hF);
		{mode, bsy} = 2'h3;
		tk(2);
		chk({pflt, foe_b, fo}, 3'h5);
		{pof_b, err, scn, bsy} = 4'h8;
		send(8'h3C);
		watch(8'h3C);
		chk({6'h00, lfd, oe_b}, 8'h02);
		$display("status test done");
	endtask : t_status
	task t_scan;
		dir = 1;
		scd = 8'hE7;
		tk(2);
		chk({lfd, oe_b}, 2'h1);
		scn = 1;
		while (rxv !== 1'b1)
			tk(1);
		chk(rxd, 8'hE7);
		chk({7'h00, srdy}, 8'h01);
		tk(2);
		chk({7'h00, rxv}, 8'h01);
		rxr = 1;
		tk(1);
		chk({7'h00, rxv}, 8'h00);
		{rxr, scn} = 2'h0;
		$display("scan test done");
	endtask : t_scan
	initial
	begin
		tk(16);
		rst_b_i = 1;
		t_print;
		t_busy;
		t_status;
		t_scan;
		give_verdict;
	end
endmodule : test_pport_core
`default_nettype wire
